// [core/intc_pkg.sv]
// Constants shared by the interrupt flag, enable and priority block
package intc_pkg;
  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int NUM_SOURCES   = 32;
  localparam int NUM_PRIO_REGS = 8;
  localparam int ADDR_W        = 6;
  localparam int ID_W          = 5;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [5:0] OFF_FLAGS    = 6'h00;
  localparam logic [5:0] OFF_ENABLE   = 6'h04;
  localparam logic [5:0] OFF_STATUS   = 6'h08;
  localparam logic [5:0] OFF_MASK     = 6'h0C;
  localparam logic [5:0] OFF_ACTIVE   = 6'h10;
  localparam logic [5:0] OFF_PRIO_LO  = 6'h20;
  localparam logic [5:0] OFF_PRIO_HI  = 6'h3C;

  // ------------------------------------------------------------------
  // Field layout of one priority byte
  // ------------------------------------------------------------------
  localparam int PRIO_LSB    = 2;
  localparam int PRIO_W      = 3;
  localparam int SUB_LSB     = 0;
  localparam int SUB_W       = 2;
  localparam logic [31:0] PRIO_IMPL_MASK = 32'h1F1F1F1F;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] RESET_WORD = 32'h00000000;

  // ------------------------------------------------------------------
  // Status bits of the block's own interrupt
  // ------------------------------------------------------------------
  localparam int ST_REQ_RISE = 0;
  localparam int ST_SEL_CHG  = 1;
  localparam int ST_W        = 2;
endpackage

// [core/intc_regs.sv]
// Interrupt flag, enable and priority registers with winner selection
`timescale 1ns/100ps
`default_nettype none
module intc_regs (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [5:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // Peripheral request pulses
  input  wire logic [31:0] source_req,
  // Request to the core
  output logic             core_req,
  output logic [4:0]       core_id,
  output logic [2:0]       core_level,
  output logic             irq
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [31:0] pending_flag_bits;
  logic [31:0] source_enable_bits;
  logic [31:0] prio_mem [0:7];
  logic [1:0]  status;
  logic [1:0]  mask;
  logic [31:0] next_flags;
  logic [31:0] next_enable;
  logic [31:0] next_prio [0:7];
  logic [1:0]  next_status;
  logic [1:0]  next_mask;
  logic [31:0] next_rdata;
  logic        next_core_req;
  logic [4:0]  next_core_id;
  logic [2:0]  next_core_level;
  logic        next_irq;

  logic [31:0]  candidate;
  logic [159:0] level_key;
  logic         any_valid;
  logic [4:0]   winner_id;
  logic [4:0]   winner_key;

  // Decoded register strobes, one per written register group plus the status read; the active word has none
  logic         wr_flags;
  logic         wr_enable;
  logic         wr_mask;
  logic         wr_prio;
  logic         rd_status;

  // Priority field of one source, pulled from its byte
  function automatic logic [2:0] prio_of(input logic [31:0] word, input logic [1:0] lane);
    logic [7:0] b;
    b = word[lane*8 +: 8];
    prio_of = b[intc_pkg::PRIO_LSB +: intc_pkg::PRIO_W];
  endfunction

  // Sub-priority field of one source
  function automatic logic [1:0] sub_of(input logic [31:0] word, input logic [1:0] lane);
    logic [7:0] b;
    b = word[lane*8 +: 8];
    sub_of = b[intc_pkg::SUB_LSB +: intc_pkg::SUB_W];
  endfunction

  // True for the eight word-aligned priority addresses; shared by the
  // write and the read decoders so the two can never disagree
  function automatic logic is_prio_addr(input logic [5:0] a);
    is_prio_addr = (a >= intc_pkg::OFF_PRIO_LO) && (a <= intc_pkg::OFF_PRIO_HI)
                   && (a[1:0] == 2'h0);
  endfunction

  // ------------------------------------------------------------------
  // Candidate sources and their sort keys
  // ------------------------------------------------------------------
  always_comb begin
    for (int s = 0; s < intc_pkg::NUM_SOURCES; s++) begin
      level_key[s*5 +: 5] = {prio_of(prio_mem[s/4], 2'(s % 4)),
                             sub_of(prio_mem[s/4], 2'(s % 4))};
      candidate[s] = pending_flag_bits[s] && source_enable_bits[s]
                     && (prio_of(prio_mem[s/4], 2'(s % 4)) != 3'h0);
    end
  end

  prio_select u_select (
    .candidate  (candidate),
    .level_key  (level_key),
    .any_valid  (any_valid),
    .winner_id  (winner_id),
    .winner_key (winner_key)
  );

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  // One decode of each strobe; the write groups and the status clear read only
  // these, while the read mux decodes addr on its own
  always_comb begin
    wr_flags  = wr && (addr == intc_pkg::OFF_FLAGS);
    wr_enable = wr && (addr == intc_pkg::OFF_ENABLE);
    wr_mask   = wr && (addr == intc_pkg::OFF_MASK);
    wr_prio   = wr && is_prio_addr(addr);
    rd_status = rd && (addr == intc_pkg::OFF_STATUS);
  end

  // ------------------------------------------------------------------
  // Pending flags
  // ------------------------------------------------------------------
  // Hardware set beats a software write of zero in the same cycle, so a
  // request that lands while software clears its flag is never lost
  always_comb begin
    next_flags = pending_flag_bits;
    if (wr_flags) begin
      next_flags = wdata;
    end
    next_flags = next_flags | source_req;
  end

  // Flag word; a flag stays set until software writes it back to zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pending_flag_bits <= intc_pkg::RESET_WORD;
    end else begin
      pending_flag_bits <= next_flags;
    end
  end

  // ------------------------------------------------------------------
  // Source enables
  // ------------------------------------------------------------------
  // Plain read/write word; a cleared bit only hides its source, while
  // the flag keeps collecting requests
  always_comb begin
    next_enable = source_enable_bits;
    if (wr_enable) begin
      next_enable = wdata;
    end
  end

  // Enable word
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      source_enable_bits <= intc_pkg::RESET_WORD;
    end else begin
      source_enable_bits <= next_enable;
    end
  end

  // ------------------------------------------------------------------
  // Priority words
  // ------------------------------------------------------------------
  // Only the five implemented bits of each byte are kept; the top three
  // are dropped on the way in, so a read can never see stale junk there
  always_comb begin
    for (int r = 0; r < intc_pkg::NUM_PRIO_REGS; r++) begin
      next_prio[r] = prio_mem[r];
    end
    if (wr_prio) begin
      next_prio[addr[4:2]] = wdata & intc_pkg::PRIO_IMPL_MASK;
    end
  end

  // Priority store, four sources per word
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int r = 0; r < intc_pkg::NUM_PRIO_REGS; r++) begin
        prio_mem[r] <= intc_pkg::RESET_WORD;
      end
    end else begin
      for (int r = 0; r < intc_pkg::NUM_PRIO_REGS; r++) begin
        prio_mem[r] <= next_prio[r];
      end
    end
  end

  // ------------------------------------------------------------------
  // Interrupt mask
  // ------------------------------------------------------------------
  // Only the two event bits exist; the rest of the write word is cut
  // on purpose and reads back as zero
  always_comb begin
    next_mask = mask;
    if (wr_mask) begin
      next_mask = wdata[intc_pkg::ST_W-1:0];
    end
  end

  // Mask bits
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mask <= 2'h0;
    end else begin
      mask <= next_mask;
    end
  end

  // ------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------
  // Read mux; unmapped addresses and idle cycles read zero
  always_comb begin
    next_rdata = 32'h00000000;
    if (rd) begin
      unique case (addr)
        intc_pkg::OFF_FLAGS:  next_rdata = pending_flag_bits;
        intc_pkg::OFF_ENABLE: next_rdata = source_enable_bits;
        intc_pkg::OFF_STATUS: next_rdata = {30'h0, status};
        intc_pkg::OFF_MASK:   next_rdata = {30'h0, mask};
        intc_pkg::OFF_ACTIVE: next_rdata = {22'h0, core_level, core_req, 1'b0, core_id};
        default: begin
          if (is_prio_addr(addr)) begin
            next_rdata = prio_mem[addr[4:2]] & intc_pkg::PRIO_IMPL_MASK;
          end
        end
      endcase
    end
  end

  // Read data stands for exactly one cycle after the strobe, then
  // returns to zero, so a late sample cannot pass by accident
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------------
  // Request to the core
  // ------------------------------------------------------------------
  // Idle outputs are forced to zero so the core never acts on a stale id
  always_comb begin
    next_core_req   = any_valid;
    next_core_id    = any_valid ? winner_id : 5'h00;
    next_core_level = any_valid ? winner_key[4:2] : 3'h0;
  end

  // Registered so the core sees a settled winner one edge after the
  // flag; costs a cycle of latency but keeps the long compare off the pins
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      core_req   <= 1'b0;
      core_id    <= 5'h00;
      core_level <= 3'h0;
    end else begin
      core_req   <= next_core_req;
      core_id    <= next_core_id;
      core_level <= next_core_level;
    end
  end

  // ------------------------------------------------------------------
  // Sticky status and the block's own interrupt
  // ------------------------------------------------------------------
  // A read of the status word clears it; an event in the same cycle
  // still sets its bit, and only the next read reports it
  always_comb begin
    next_status = status;
    if (rd_status) begin
      next_status = 2'h0;
    end
    // Events set after the read clear so none is lost
    if (any_valid && !core_req) begin
      next_status[intc_pkg::ST_REQ_RISE] = 1'b1;
    end
    if (any_valid && core_req && winner_id != core_id) begin
      next_status[intc_pkg::ST_SEL_CHG] = 1'b1;
    end
    // Built from next values so irq rises with its status bit
    next_irq = |(next_status & next_mask);
  end

  // Status bits and the level interrupt
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status <= 2'h0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= next_irq;
    end
  end
endmodule // intc_regs
`default_nettype wire

// [core/prio_select.sv]
// Picks the winning source by priority then sub-priority
`timescale 1ns/100ps
`default_nettype none
module prio_select (
  // Candidate sources
  input  wire logic [31:0]  candidate,
  input  wire logic [159:0] level_key,
  // Winner
  output logic              any_valid,
  output logic [4:0]        winner_id,
  output logic [4:0]        winner_key
);
  int i;

  // Strictly greater keeps the lowest index among equal keys
  always_comb begin
    any_valid  = 1'b0;
    winner_id  = 5'h00;
    winner_key = 5'h00;
    for (i = 0; i < intc_pkg::NUM_SOURCES; i++) begin
      if (candidate[i] && (!any_valid || level_key[i*5 +: 5] > winner_key)) begin
        any_valid  = 1'b1;
        winner_id  = i[4:0];
        winner_key = level_key[i*5 +: 5];
      end
    end
  end
endmodule // prio_select
`default_nettype wire

// [verif/intc_regs_sva.sv]
// Checker for the interrupt flag, enable and priority block
`timescale 1ns/100ps
`default_nettype none
module intc_regs_sva (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // Register port
  input wire logic [5:0]  addr,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Sources and core side
  input wire logic [31:0] source_req,
  input wire logic        core_req,
  input wire logic [4:0]  core_id,
  input wire logic [2:0]  core_level,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rd_idle; !rd |=> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_rsv; rd && addr[5] |=> (rdata & 32'hE0E0E0E0) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_hole; rd && addr inside {6'h14, 6'h18, 6'h1C} |=> rdata == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("hole not zero");
  property p_lvl; core_req |-> core_level != 3'h0; endproperty
  a_lvl: assert property (p_lvl) else $error("level zero served");
  property p_idle; !core_req |-> core_id == 5'h00 && core_level == 3'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle id");
  property p_hold; core_req && !wr && !$past(wr) |=> core_req; endproperty
  a_hold: assert property (p_hold) else $error("req dropped");
  // Winner may only move after a write or a new request
  property p_stable;
    (!wr && source_req == 32'h0)[*2] |=> $stable(core_id) && $stable(core_level);
  endproperty
  a_stable: assert property (p_stable) else $error("winner moved");
  property p_cause;
    $rose(core_req) |-> $past(wr) || $past(wr, 2) || $past(source_req != 32'h0, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("req uncaused");
  c_req: cover property (core_req);
  c_irq: cover property (irq);
  c_rsv: cover property (rd && addr[5]);
endmodule // intc_regs_sva
bind intc_regs intc_regs_sva chk (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wr(wr),
  .rd(rd), .rdata(rdata), .source_req(source_req), .core_req(core_req),
  .core_id(core_id), .core_level(core_level), .irq(irq));
`default_nettype wire

// [verif/src_model.sv]
// Peripheral request sources, prompt or two cycles late
`timescale 1ns/100ps
`default_nettype none
module src_model (
  // Clock, reset and command
  input wire logic         ref_clk,
  input wire logic         reset,
  input wire logic [31:0]  fire,
  input wire logic         slow,
  // Request pulses
  output var logic [31:0]  source_req
);
  logic [31:0] d0, d1;
  // One-cycle pulses; lines idle low between events
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      {d0, d1, source_req} <= '0;
    end else begin
      d0 <= fire;
      d1 <= d0;
      source_req <= slow ? d1 : fire;
    end
  end
endmodule // src_model
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the interrupt flag, enable and priority block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        ref_clk, reset, wr, rd, slow, core_req, irq;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata, source_req, fire, got;
  logic [4:0]  core_id;
  logic [2:0]  core_level;
  int          error_cnt, check_count;
  intc_regs uut (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .source_req(source_req), .core_req(core_req),
    .core_id(core_id), .core_level(core_level), .irq(irq));
  src_model src (.ref_clk(ref_clk), .reset(reset), .fire(fire), .slow(slow),
    .source_req(source_req));
  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [5:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    rd_reg(a);
    chk($sformatf("reg %h", a), e, got);
  endtask
  task automatic core_chk(input logic [8:0] e);
    #1 chk("core", {23'h0, e}, {23'h0, core_req, core_id, core_level});
  endtask
  // Flag lands one edge after the pulse, outputs one edge later
  task automatic pulse(input logic [31:0] f, input logic s);
    @(posedge ref_clk);
    fire <= f;
    slow <= s;
    @(posedge ref_clk);
    fire <= 32'h0;
    repeat (s ? 6 : 3) @(posedge ref_clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    {wr, rd, slow, addr, wdata, fire} = '0;
    reset = 1'b1;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    for (int a = 0; a < 64; a += 4) rd_chk(a[5:0], 32'h0);
    wr_reg(6'h04, 32'hA5A50F0F);
    rd_chk(6'h04, 32'hA5A50F0F);
    wr_reg(6'h00, 32'h000000F0);
    rd_chk(6'h00, 32'h000000F0);
    wr_reg(6'h20, 32'hFFFFFFFF);
    rd_chk(6'h20, 32'h1F1F1F1F);
    core_chk(9'h000);
    wr_reg(6'h00, 32'h0);
    wr_reg(6'h04, 32'h00000038);
    wr_reg(6'h0C, 32'h00000001);
    wr_reg(6'h20, 32'h15000000);
    pulse(32'h00000008, 1'b0);
    core_chk({1'b1, 5'h03, 3'h5});
    chk("irq", 32'h1, {31'h0, irq});
    rd_chk(6'h00, 32'h00000008);
    rd_reg(6'h08);
    chk("status", 32'h1, got & 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    wr_reg(6'h20, 32'h01000000);
    repeat (2) @(posedge ref_clk);
    core_chk(9'h000);
    wr_reg(6'h24, 32'h00000B09);
    pulse(32'h00000030, 1'b0);
    core_chk({1'b1, 5'h05, 3'h2});
    wr_reg(6'h24, 32'h00000809);
    repeat (2) @(posedge ref_clk);
    core_chk({1'b1, 5'h04, 3'h2});
    rd_chk(6'h08, 32'h00000003);
    chk("irq", 32'h0, {31'h0, irq});
    rd_chk(6'h10, 32'h00000144);
    wr_reg(6'h04, 32'h80000038);
    wr_reg(6'h3C, 32'h1C000000);
    pulse(32'h80000000, 1'b1);
    core_chk({1'b1, 5'h1F, 3'h7});
    wr_reg(6'h04, 32'h0);
    repeat (2) @(posedge ref_clk);
    core_chk(9'h000);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
